/* File: rtl/pgm_top.sv */
// Power-good output source masks: mask registers, two trees, registered outputs
//
// Contract
// (R1) Upper bits 7..4 mask enable inputs 5,4,2,1
// (R2) Upper bit 3 masks termination regulator flag
// (R3) Upper bit 2 masks variant-selected shared slot
// (R4) Upper bits 1,0 mask switch B1, regulator 3
// (R5) Out-four lower: reg2, switch A1, stepdowns 6..1
// (R6) Set mask bit drops source from output four
// (R7) Out-one upper mask at 0xa5, read/write
// (R8) Out-four lower mask at 0xa6, read/write
// (R9) Out-four upper mask at 0xa7, same fields
// (R10) Reset patterns come from the factory variant
// (R11) Out-one lower mask at 0xa4, same encoding
// (R12) Output good only while all unmasked good
`timescale 1ns/100ps
`default_nettype none
module pgm_top
    import pgm_pkg::*;
#(
    parameter int unsigned VARIANT = 0
)
(
    input wire logic clock,
    input wire logic rst,
    // Register port from the host serial interface
    input wire logic [PGM_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [PGM_DATA_W-1:0] reg_wdata,
    output logic [PGM_DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Rail good flags and enable input status
    input wire logic [5:0] stepdown_good,
    input wire logic load_switch_a_one_good,
    input wire logic adj_regulator_two_good,
    input wire logic adj_regulator_three_good,
    input wire logic adj_regulator_one_good,
    input wire logic load_switch_b_one_good,
    input wire logic load_switch_b_two_good,
    input wire logic termination_regulator_good,
    input wire logic enable_in_one,
    input wire logic enable_in_two,
    input wire logic enable_in_four,
    input wire logic enable_in_five,
    // Power-good output pins
    output logic power_good_output_one,
    output logic power_good_output_four
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check

    if (VARIANT >= PGM_VARIANTS) begin : g_bad_variant
        $error("pgm_top: VARIANT out of range");
    end

    // Both trees take one byte of sources from each source register
    if (PGM_SRC_W != 2 * PGM_DATA_W) begin : g_bad_src_width
        $error("pgm_top: source vector must span two register bytes");
    end

    if (PGM_BIT_STEPDOWN_SIX - PGM_BIT_STEPDOWN_ONE != 5) begin : g_bad_stepdown
        $error("pgm_top: step-down field must hold six rails");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source vectors

    logic shared_slot_good;
    logic [7:0] src_lower;
    logic [7:0] src_upper;

    // Slot wiring fixed per variant, not switchable by software
    assign shared_slot_good = (VARIANT == PGM_VARIANT_SHARED_IS_SWITCH) ?
        load_switch_b_two_good : adj_regulator_one_good; // [R3]

    assign src_lower[PGM_BIT_ADJ_REGULATOR_TWO] = adj_regulator_two_good; // [R5]
    assign src_lower[PGM_BIT_LOAD_SWITCH_A_ONE] = load_switch_a_one_good; // [R5]
    assign src_lower[PGM_BIT_STEPDOWN_SIX:PGM_BIT_STEPDOWN_ONE] = stepdown_good; // [R5]

    assign src_upper[PGM_BIT_ENABLE_IN_FIVE] = enable_in_five; // [R1]
    assign src_upper[PGM_BIT_ENABLE_IN_FOUR] = enable_in_four; // [R1]
    assign src_upper[PGM_BIT_ENABLE_IN_TWO] = enable_in_two; // [R1]
    assign src_upper[PGM_BIT_ENABLE_IN_ONE] = enable_in_one; // [R1]
    assign src_upper[PGM_BIT_TERMINATION_REG] = termination_regulator_good; // [R2]
    assign src_upper[PGM_BIT_SHARED_SLOT] = shared_slot_good; // [R3]
    assign src_upper[PGM_BIT_LOAD_SWITCH_B_ONE] = load_switch_b_one_good; // [R4]
    assign src_upper[PGM_BIT_ADJ_REGULATOR_THREE] = adj_regulator_three_good; // [R4]

    ////////////////////////////////////////////////////////////////////////////
    // Mask registers

    logic [7:0] o1_lower_q;
    logic [7:0] o1_upper_q;
    logic [7:0] o4_lower_q;
    logic [7:0] o4_upper_q;
    logic hit_o1_lower;
    logic hit_o1_upper;
    logic hit_o4_lower;
    logic hit_o4_upper;
    logic wr_o1_lower;
    logic wr_o1_upper;
    logic wr_o4_lower;
    logic wr_o4_upper;

    assign hit_o1_lower = (reg_addr == PGM_OFS_O1_LOWER); // [R11]
    assign hit_o1_upper = (reg_addr == PGM_OFS_O1_UPPER); // [R7]
    assign hit_o4_lower = (reg_addr == PGM_OFS_O4_LOWER); // [R8]
    assign hit_o4_upper = (reg_addr == PGM_OFS_O4_UPPER); // [R9]

    // Writes to status or unmapped offsets fall through and change nothing
    assign wr_o1_lower = reg_wr & hit_o1_lower; // [R11]
    assign wr_o1_upper = reg_wr & hit_o1_upper; // [R7]
    assign wr_o4_lower = reg_wr & hit_o4_lower; // [R8]
    assign wr_o4_upper = reg_wr & hit_o4_upper; // [R9]

    // Reset constants picked by the variant parameter
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            o1_lower_q <= PGM_RST_O1_LOWER[VARIANT]; // [R10]
        end else if (wr_o1_lower) begin
            o1_lower_q <= reg_wdata; // [R11]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            o1_upper_q <= PGM_RST_O1_UPPER[VARIANT]; // [R10]
        end else if (wr_o1_upper) begin
            o1_upper_q <= reg_wdata; // [R7]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            o4_lower_q <= PGM_RST_O4_LOWER[VARIANT]; // [R10]
        end else if (wr_o4_lower) begin
            o4_lower_q <= reg_wdata; // [R8]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            o4_upper_q <= PGM_RST_O4_UPPER[VARIANT]; // [R10]
        end else if (wr_o4_upper) begin
            o4_upper_q <= reg_wdata; // [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trees and outputs

    pgm_tree_if tree_one ();
    pgm_tree_if tree_four ();

    assign tree_one.src = {src_upper, src_lower};
    assign tree_one.ignore = {o1_upper_q, o1_lower_q}; // [R1] [R2] [R4] [R11]
    assign tree_four.src = {src_upper, src_lower};
    assign tree_four.ignore = {o4_upper_q, o4_lower_q}; // [R5] [R6] [R9]

    pgm_tree u_tree_one (
        .t (tree_one.tree)
    );

    pgm_tree u_tree_four (
        .t (tree_four.tree)
    );

    // One flop of latency keeps the pins glitch-free while flags settle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            power_good_output_one <= 1'b0;
        end else begin
            power_good_output_one <= tree_one.good; // [R12]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            power_good_output_four <= 1'b0;
        end else begin
            power_good_output_four <= tree_four.good; // [R6] [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [7:0] out_status;
    logic [7:0] rd_mux;

    assign out_status = {6'h00, power_good_output_four, power_good_output_one};

    always_comb begin
        rd_mux = PGM_UNMAPPED_DATA;
        unique case (reg_addr)
            PGM_OFS_O1_LOWER: rd_mux = o1_lower_q;
            PGM_OFS_O1_UPPER: rd_mux = o1_upper_q; // [R7]
            PGM_OFS_O4_LOWER: rd_mux = o4_lower_q; // [R8]
            PGM_OFS_O4_UPPER: rd_mux = o4_upper_q; // [R9]
            PGM_OFS_SRC_LOWER: rd_mux = src_lower;
            PGM_OFS_SRC_UPPER: rd_mux = src_upper;
            PGM_OFS_OUT_STATUS: rd_mux = out_status;
            default: rd_mux = PGM_UNMAPPED_DATA;
        endcase
    end

    // Answer strobe follows every read by one cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // Data holds after the read until the next read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

endmodule
`default_nettype wire

/* File: shared/pgm_pkg.sv */
// Package: offsets, field positions and per-variant reset patterns of the power-good masks
package pgm_pkg;

    localparam int unsigned PGM_ADDR_W = 8;
    localparam int unsigned PGM_DATA_W = 8;
    localparam int unsigned PGM_SRC_W = 16;
    localparam int unsigned PGM_VARIANTS = 4;

    // Register offsets on the register port
    localparam logic [7:0] PGM_OFS_O1_LOWER = 8'ha4;
    localparam logic [7:0] PGM_OFS_O1_UPPER = 8'ha5;
    localparam logic [7:0] PGM_OFS_O4_LOWER = 8'ha6;
    localparam logic [7:0] PGM_OFS_O4_UPPER = 8'ha7;
    localparam logic [7:0] PGM_OFS_SRC_LOWER = 8'hf0;
    localparam logic [7:0] PGM_OFS_SRC_UPPER = 8'hf1;
    localparam logic [7:0] PGM_OFS_OUT_STATUS = 8'hf2;
    localparam logic [7:0] PGM_UNMAPPED_DATA = 8'h00;

    // Lower-source register fields
    localparam int unsigned PGM_BIT_ADJ_REGULATOR_TWO = 7;
    localparam int unsigned PGM_BIT_LOAD_SWITCH_A_ONE = 6;
    localparam int unsigned PGM_BIT_STEPDOWN_SIX = 5;
    localparam int unsigned PGM_BIT_STEPDOWN_ONE = 0;

    // Upper-source register fields
    localparam int unsigned PGM_BIT_ENABLE_IN_FIVE = 7;
    localparam int unsigned PGM_BIT_ENABLE_IN_FOUR = 6;
    localparam int unsigned PGM_BIT_ENABLE_IN_TWO = 5;
    localparam int unsigned PGM_BIT_ENABLE_IN_ONE = 4;
    localparam int unsigned PGM_BIT_TERMINATION_REG = 3;
    localparam int unsigned PGM_BIT_SHARED_SLOT = 2;
    localparam int unsigned PGM_BIT_LOAD_SWITCH_B_ONE = 1;
    localparam int unsigned PGM_BIT_ADJ_REGULATOR_THREE = 0;

    // Output status register fields
    localparam int unsigned PGM_BIT_STAT_OUT_ONE = 0;
    localparam int unsigned PGM_BIT_STAT_OUT_FOUR = 1;

    // Variant whose shared slot carries the second load switch of group B
    localparam int unsigned PGM_VARIANT_SHARED_IS_SWITCH = 3;

    typedef logic [7:0] pgm_byte_t;
    typedef pgm_byte_t [PGM_VARIANTS-1:0] pgm_table_t;

    // Factory reset patterns, index is the variant number
    localparam pgm_table_t PGM_RST_O1_LOWER = '{8'hfc, 8'hfe, 8'h5c, 8'hfd};
    localparam pgm_table_t PGM_RST_O1_UPPER = '{8'hef, 8'hff, 8'heb, 8'hff};
    localparam pgm_table_t PGM_RST_O4_LOWER = '{8'hff, 8'hf7, 8'hbf, 8'hf7};
    localparam pgm_table_t PGM_RST_O4_UPPER = '{8'hff, 8'h7f, 8'hff, 8'hbf};

    // A source counts when it is good or when its mask bit ignores it
    function automatic logic pgm_tree_good(input logic [PGM_SRC_W-1:0] src,
                                           input logic [PGM_SRC_W-1:0] ignore);
        pgm_tree_good = &(src | ignore);
    endfunction

endpackage

/* File: shared/pgm_tree_if.sv */
// Interface: one power-good tree, its sources, its mask and its verdict
`timescale 1ns/100ps
`default_nettype none
interface pgm_tree_if;
    import pgm_pkg::*;
    logic [PGM_SRC_W-1:0] src;
    logic [PGM_SRC_W-1:0] ignore;
    logic good;
    modport owner (output src, output ignore, input good);
    modport tree (input src, input ignore, output good);
endinterface
`default_nettype wire

/* File: rtl/pgm_tree.sv */
// Power-good tree: AND of every source that its mask does not ignore
`timescale 1ns/100ps
`default_nettype none
module pgm_tree
    import pgm_pkg::*;
(
    pgm_tree_if.tree t
);
    assign t.good = pgm_tree_good(t.src, t.ignore); // [R6] [R12]
endmodule
`default_nettype wire

/* File: tb/pgm_pg_monitor.sv */
// Model of the system logic that samples both power-good pins
`timescale 1ns/100ps
`default_nettype none
module pgm_pg_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic pg_one,
    input wire logic pg_four,
    output logic [1:0] seen_q
);
    // One sampling stage, as a controller would register the pins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            seen_q <= 2'h0;
        end else begin
            seen_q <= {pg_four, pg_one};
        end
    end
endmodule
`default_nettype wire

/* File: tb/pgm_top_sva.sv */
// Checker: register port and status behaviour of the mask block
`timescale 1ns/100ps
`default_nettype none
module pgm_top_chk
    import pgm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [PGM_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [PGM_DATA_W-1:0] reg_wdata,
    input wire logic [PGM_DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic power_good_output_one,
    input wire logic power_good_output_four
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire mapped = reg_addr inside {[PGM_OFS_O1_LOWER:PGM_OFS_O4_UPPER],
        [PGM_OFS_SRC_LOWER:PGM_OFS_OUT_STATUS]};
    // Write then read on the next edge must return the written byte
    property p_back(logic [7:0] a);
        reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    chk_read_answered: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    chk_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without read");
    chk_o1_lower_back: assert property (p_back(PGM_OFS_O1_LOWER))
        else $error("a4 readback wrong");
    chk_o1_upper_back: assert property (p_back(PGM_OFS_O1_UPPER))
        else $error("a5 readback wrong");
    chk_o4_lower_back: assert property (p_back(PGM_OFS_O4_LOWER))
        else $error("a6 readback wrong");
    chk_o4_upper_back: assert property (p_back(PGM_OFS_O4_UPPER))
        else $error("a7 readback wrong");
    chk_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == PGM_UNMAPPED_DATA)
        else $error("unmapped read not zero");
    chk_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved");
    chk_status_mirror: assert property (reg_rd && reg_addr == PGM_OFS_OUT_STATUS |=>
        reg_rdata == {6'h00, $past(power_good_output_four), $past(power_good_output_one)})
        else $error("status differs from pins");
    cover property (p_back(PGM_OFS_O1_UPPER));
    cover property (reg_rd && !mapped);
    cover property ($fell(power_good_output_four));
    cover property (power_good_output_four && !power_good_output_one);
endmodule
bind pgm_top pgm_top_chk u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .power_good_output_one(power_good_output_one),
    .power_good_output_four(power_good_output_four));
`default_nettype wire

/* File: tb/test_power_good_output_source_masks.sv */
// Testbench: reset patterns, register access and both power-good trees
`timescale 1ns/100ps
`default_nettype none
module test_power_good_output_source_masks;
    import pgm_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [15:0] src = 16'h0000;
    logic [15:0] m;
    logic pg_one;
    logic pg_four;
    logic [1:0] seen_q;
    logic [7:0] rst_tab [4] = '{8'hfd, 8'hff, 8'hf7, 8'hbf};
    int fail_count = 0;
    int n_compared = 0;
    always #4 clock = ~clock;
    // Second switch of group B is driven opposite: variant 0 must not use it
    pgm_top #(.VARIANT(0)) dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .stepdown_good(src[5:0]), .load_switch_a_one_good(src[6]),
        .adj_regulator_two_good(src[7]), .adj_regulator_three_good(src[8]),
        .load_switch_b_one_good(src[9]), .adj_regulator_one_good(src[10]),
        .load_switch_b_two_good(~src[10]), .termination_regulator_good(src[11]),
        .enable_in_one(src[12]), .enable_in_two(src[13]), .enable_in_four(src[14]),
        .enable_in_five(src[15]), .power_good_output_one(pg_one),
        .power_good_output_four(pg_four));
    pgm_pg_monitor mon (.clock(clock), .rst(rst), .pg_one(pg_one), .pg_four(pg_four),
        .seen_q(seen_q));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
    endtask
    // Read issued on the edge right after the write
    task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, d);
    endtask
    task automatic pins(input logic [7:0] exp);
        repeat (4) @(posedge clock);
        #1;
        chk({6'h00, seen_q}, exp);
        @(posedge clock);
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(PGM_OFS_O1_LOWER + 8'(i), rst_tab[i]);
            wrrd(PGM_OFS_O1_LOWER + 8'(i), 8'hff);
        end
        rd(8'h3c, PGM_UNMAPPED_DATA);
        pins(8'h03);
        // One source included at a time in both trees, low then good
        for (int i = 0; i < 16; i++) begin
            src <= 16'h0000;
            m = ~(16'h0001 << i);
            wrrd(PGM_OFS_O1_LOWER, m[7:0]);
            wrrd(PGM_OFS_O1_UPPER, m[15:8]);
            wrrd(PGM_OFS_O4_LOWER, m[7:0]);
            wrrd(PGM_OFS_O4_UPPER, m[15:8]);
            pins(8'h00);
            src <= 16'h0001 << i;
            pins(8'h03);
        end
        src <= 16'hffff;
        pins(8'h03);
        rd(PGM_OFS_OUT_STATUS, 8'h03);
        // Only enable input five counts now, and it reads low
        @(posedge clock);
        src <= 16'h5a3c;
        pins(8'h00);
        rd(PGM_OFS_SRC_LOWER, 8'h3c);
        rd(PGM_OFS_SRC_UPPER, 8'h5a);
        // Tree one takes every source, tree four none, then tree one none and tree four the upper byte only
        wrrd(PGM_OFS_O1_LOWER, 8'h00);
        wrrd(PGM_OFS_O1_UPPER, 8'h00);
        wrrd(PGM_OFS_O4_LOWER, 8'hff);
        wrrd(PGM_OFS_O4_UPPER, 8'hff);
        pins(8'h02);
        rd(PGM_OFS_OUT_STATUS, 8'h02);
        wrrd(PGM_OFS_O1_LOWER, 8'hff);
        wrrd(PGM_OFS_O1_UPPER, 8'hff);
        wrrd(PGM_OFS_O4_UPPER, 8'h00);
        pins(8'h01);
        // Reset in mid-run reloads the variant pattern over written values
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(PGM_OFS_O1_LOWER + 8'(i), rst_tab[i]);
        end
        pins(8'h02);
        wrap_up();
    end
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
